//--- rtl/spipin_consts.svh
// Constants of the shared-pin serial peripheral port.
// Assumes the core clock period below matches the clock on clk_i.
`ifndef SPIPIN_CONSTS_SVH
`define SPIPIN_CONSTS_SVH

`define SPIPIN_CLK_PERIOD_NS 5
`define SPIPIN_SCLK_HALF_NS 50
// Core cycles per serial clock half, rounded up
`define SPIPIN_HALF_CYC ((`SPIPIN_SCLK_HALF_NS + \
    `SPIPIN_CLK_PERIOD_NS - 1) / `SPIPIN_CLK_PERIOD_NS)
`define SPIPIN_BITS 8
`define SPIPIN_LAST_BIT 3'h7
`define SPIPIN_PIN_MISO 0
`define SPIPIN_PIN_MOSI 1
`define SPIPIN_PIN_SCLK 2
`define SPIPIN_PIN_SEL 3
`define SPIPIN_SEL_RST 4'h0
// Synchronisers wake reading every pin high, select idle
`define SPIPIN_SYNC_RST 4'hf

`endif

//--- rtl/spipin_pkg.sv
// Types of the shared-pin serial peripheral port.
// Assumes nothing beyond a SystemVerilog compiler.
package spipin_pkg;
    typedef logic [7:0] spipin_byte_t;
    typedef logic [3:0] spipin_pins_t;
    typedef enum logic [2:0] {
        SPIPIN_IDLE = 3'h1,
        SPIPIN_SHIFT = 3'h2,
        SPIPIN_FAULT = 3'h4
    } spipin_state_t;
endpackage

//--- rtl/spipin_top.sv
// Serial peripheral port on four shared port pins, master or slave.
// Assumes the pad ring resolves each pin from its output enable and
// that the select line is active low. Fixed clock polarity 0, phase 0.
`timescale 1ns/1ps
`include "spipin_consts.svh"

module spipin_top (
    // Core clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Mode and fault control
    input wire logic master_mode_i,
    input wire logic fault_clear_i,
    output logic mode_fault_o,
    output logic busy_o,
    // Pin ownership and port-pin use
    input wire logic pin_sel_we_i,
    input wire spipin_pkg::spipin_pins_t pin_sel_i,
    input wire spipin_pkg::spipin_pins_t gpio_dir_i,
    input wire spipin_pkg::spipin_pins_t gpio_out_i,
    output spipin_pkg::spipin_pins_t gpio_in_o,
    // Transmit byte
    input wire logic tx_valid_i,
    input wire spipin_pkg::spipin_byte_t tx_data_i,
    output logic tx_ready_o,
    // Received byte
    output logic rx_valid_o,
    output spipin_pkg::spipin_byte_t rx_data_o,
    // Master-in/slave-out pin
    input wire logic port_pin_shared_miso_i,
    output logic port_pin_shared_miso_o,
    output logic port_pin_shared_miso_oe_o,
    // Master-out/slave-in pin
    input wire logic port_pin_shared_mosi_i,
    output logic port_pin_shared_mosi_o,
    output logic port_pin_shared_mosi_oe_o,
    // Serial clock pin, also the slave link clock
    input wire logic port_pin_shared_sclk_i,
    output logic port_pin_shared_sclk_o,
    output logic port_pin_shared_sclk_oe_o,
    // Select pin, active low in serial use
    input wire logic port_pin_shared_select_n_i,
    output logic port_pin_shared_select_n_o,
    output logic port_pin_shared_select_n_oe_o
);
    import spipin_pkg::*;

    spipin_pins_t pin_sel_q;
    spipin_pins_t pins_raw;
    spipin_pins_t pins_s1_q;
    spipin_pins_t pins_s2_q;
    spipin_state_t state_q;
    logic [7:0] half_q;
    logic [2:0] bit_q;
    logic sclk_q;
    spipin_byte_t mtx_q;
    spipin_byte_t mrx_q;
    logic mosi_q;
    logic fault_q;
    spipin_byte_t stx_q;
    spipin_byte_t rx_q;
    logic rx_valid_q;
    logic half_done;
    logic sel_low;
    logic slv_rst_n;
    logic [2:0] sbit_q;
    spipin_byte_t ssh_q;
    spipin_byte_t shold_q;
    logic stgl_q;
    logic tgl_s1_q;
    logic tgl_s2_q;
    logic tgl_s3_q;

    // Pins default to the serial function after reset
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_sel_q <= `SPIPIN_SEL_RST;
        end else if (pin_sel_we_i) begin
            pin_sel_q <= pin_sel_i;
        end
    end

    // Two-stage synchronisers on every pin level read by core logic
    assign pins_raw = {port_pin_shared_select_n_i, port_pin_shared_sclk_i,
                       port_pin_shared_mosi_i, port_pin_shared_miso_i};
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pins_s1_q <= `SPIPIN_SYNC_RST;
            pins_s2_q <= `SPIPIN_SYNC_RST;
        end else begin
            pins_s1_q <= pins_raw;
            pins_s2_q <= pins_s1_q;
        end
    end
    assign gpio_in_o = pins_s2_q;
    assign sel_low = !pins_s2_q[`SPIPIN_PIN_SEL];

    // Master clock divider: one half period per terminal count
    assign half_done = (half_q == 8'(`SPIPIN_HALF_CYC - 1));
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            half_q <= 8'h00;
        end else if (state_q != SPIPIN_SHIFT || half_done) begin
            half_q <= 8'h00;
        end else begin
            half_q <= half_q + 8'h01;
        end
    end

    // Master sequencer; select low means another master owns the bus
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= SPIPIN_IDLE;
        end else begin
            case (state_q)
                SPIPIN_IDLE: begin
                    if (master_mode_i && sel_low) begin
                        state_q <= SPIPIN_FAULT;
                    end else if (master_mode_i && tx_valid_i) begin
                        state_q <= SPIPIN_SHIFT;
                    end
                end
                SPIPIN_SHIFT: begin
                    if (sel_low) begin
                        state_q <= SPIPIN_FAULT;
                    end else if (half_done && sclk_q &&
                                 bit_q == `SPIPIN_LAST_BIT) begin
                        state_q <= SPIPIN_IDLE;
                    end
                end
                SPIPIN_FAULT: begin
                    if (fault_clear_i && !sel_low) begin
                        state_q <= SPIPIN_IDLE;
                    end
                end
                default: begin
                    state_q <= SPIPIN_IDLE;
                end
            endcase
        end
    end

    // Sticky fault flag; a new fault wins over a clear
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fault_q <= 1'b0;
        end else if (master_mode_i && sel_low &&
                     state_q != SPIPIN_FAULT) begin
            fault_q <= 1'b1;
        end else if (fault_clear_i && state_q == SPIPIN_FAULT &&
                     !sel_low) begin
            fault_q <= 1'b0;
        end
    end

    // Master shift: sample on rise, next bit on fall, half period ahead
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sclk_q <= 1'b0;
            bit_q <= 3'h0;
            mtx_q <= 8'h00;
            mrx_q <= 8'h00;
            mosi_q <= 1'b0;
        end else if (state_q == SPIPIN_IDLE && master_mode_i &&
                     tx_valid_i && !sel_low) begin
            mtx_q <= {tx_data_i[6:0], 1'b0};
            mosi_q <= tx_data_i[7];
            bit_q <= 3'h0;
            sclk_q <= 1'b0;
        end else if (state_q != SPIPIN_SHIFT) begin
            sclk_q <= 1'b0;
        end else if (half_done) begin
            sclk_q <= !sclk_q;
            if (!sclk_q) begin
                mrx_q <= {mrx_q[6:0], pins_s2_q[`SPIPIN_PIN_MISO]};
            end else begin
                mosi_q <= mtx_q[7];
                mtx_q <= {mtx_q[6:0], 1'b0};
                bit_q <= bit_q + 3'h1;
            end
        end
    end

    // Slave reply byte; changed only while deselected, read by the link
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stx_q <= 8'h00;
        end else if (!master_mode_i && !sel_low && tx_valid_i) begin
            stx_q <= tx_data_i;
        end
    end

    // Slave link domain, held in reset while deselected
    assign slv_rst_n = rst_n_i & !port_pin_shared_select_n_i;
    always_ff @(posedge port_pin_shared_sclk_i or negedge slv_rst_n) begin
        if (!slv_rst_n) begin
            sbit_q <= 3'h0;
            ssh_q <= 8'h00;
        end else begin
            ssh_q <= {ssh_q[6:0], port_pin_shared_mosi_i};
            sbit_q <= sbit_q + 3'h1;
        end
    end

    // Completed byte and its toggle survive the deselect
    always_ff @(posedge port_pin_shared_sclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shold_q <= 8'h00;
            stgl_q <= 1'b0;
        end else if (!port_pin_shared_select_n_i &&
                     sbit_q == `SPIPIN_LAST_BIT) begin
            shold_q <= {ssh_q[6:0], port_pin_shared_mosi_i};
            stgl_q <= !stgl_q;
        end
    end

    // Toggle crossing into the core; third stage finds the edge
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tgl_s1_q <= 1'b0;
            tgl_s2_q <= 1'b0;
            tgl_s3_q <= 1'b0;
        end else begin
            tgl_s1_q <= stgl_q;
            tgl_s2_q <= tgl_s1_q;
            tgl_s3_q <= tgl_s2_q;
        end
    end

    // Received byte from either role, one pulse per byte
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_q <= 8'h00;
            rx_valid_q <= 1'b0;
        end else if (state_q == SPIPIN_SHIFT && half_done && sclk_q &&
                     bit_q == `SPIPIN_LAST_BIT && !sel_low) begin
            rx_q <= mrx_q;
            rx_valid_q <= 1'b1;
        end else if (!master_mode_i && tgl_s2_q != tgl_s3_q) begin
            rx_q <= shold_q; // Stable: next byte is eight clocks away
            rx_valid_q <= 1'b1;
        end else begin
            rx_valid_q <= 1'b0;
        end
    end

    // Core-side status and handshake
    assign rx_valid_o = rx_valid_q;
    assign rx_data_o = rx_q;
    assign mode_fault_o = fault_q;
    assign busy_o = (state_q == SPIPIN_SHIFT) || (!master_mode_i && sel_low);
    assign tx_ready_o = master_mode_i ? (state_q == SPIPIN_IDLE && !sel_low)
                                      : !sel_low;

    // Pin drivers: port use overrides the serial function per pin
    always_comb begin
        port_pin_shared_miso_o = stx_q[~sbit_q];
        port_pin_shared_miso_oe_o = !master_mode_i && sel_low;
        port_pin_shared_mosi_o = mosi_q;
        port_pin_shared_mosi_oe_o = master_mode_i &&
                                    state_q != SPIPIN_FAULT;
        port_pin_shared_sclk_o = sclk_q;
        port_pin_shared_sclk_oe_o = master_mode_i &&
                                    state_q != SPIPIN_FAULT;
        port_pin_shared_select_n_o = 1'b1;
        port_pin_shared_select_n_oe_o = 1'b0;
        if (pin_sel_q[`SPIPIN_PIN_MISO]) begin
            port_pin_shared_miso_o = gpio_out_i[`SPIPIN_PIN_MISO];
            port_pin_shared_miso_oe_o = gpio_dir_i[`SPIPIN_PIN_MISO];
        end
        if (pin_sel_q[`SPIPIN_PIN_MOSI]) begin
            port_pin_shared_mosi_o = gpio_out_i[`SPIPIN_PIN_MOSI];
            port_pin_shared_mosi_oe_o = gpio_dir_i[`SPIPIN_PIN_MOSI];
        end
        if (pin_sel_q[`SPIPIN_PIN_SCLK]) begin
            port_pin_shared_sclk_o = gpio_out_i[`SPIPIN_PIN_SCLK];
            port_pin_shared_sclk_oe_o = gpio_dir_i[`SPIPIN_PIN_SCLK];
        end
        if (pin_sel_q[`SPIPIN_PIN_SEL]) begin
            port_pin_shared_select_n_o = gpio_out_i[`SPIPIN_PIN_SEL];
            port_pin_shared_select_n_oe_o = gpio_dir_i[`SPIPIN_PIN_SEL];
        end
    end
endmodule

//--- testbench/spipin_top_asserts.sv
// Timing and direction checks on the shared-pin serial port.
// Assumes the pins stay serial while gpio_dir_i is zero.
`timescale 1ns/1ps
module spipin_top_asserts (
    // Clock, reset and controls
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic master_mode_i,
    input wire spipin_pkg::spipin_pins_t gpio_dir_i,
    // Watched pins and flags
    input wire logic mode_fault_o,
    input wire logic port_pin_shared_select_n_i,
    input wire logic port_pin_shared_miso_oe_o,
    input wire logic port_pin_shared_mosi_o,
    input wire logic port_pin_shared_mosi_oe_o,
    input wire logic port_pin_shared_sclk_o,
    input wire logic port_pin_shared_sclk_oe_o
);
    import spipin_pkg::*;
    // Port use moves the enables, so serial checks pause then
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i || gpio_dir_i != 4'h0);
    // Select passes a synchroniser, hence the long runs
    sequence s_off;
        (!master_mode_i && port_pin_shared_select_n_i)[*5];
    endsequence
    sequence s_on;
        (!master_mode_i && !port_pin_shared_select_n_i)[*5];
    endsequence
    sequence s_high;
        port_pin_shared_sclk_o[*8] ##1 port_pin_shared_sclk_o[*2];
    endsequence
    property p_hiz;
        s_off |-> !port_pin_shared_miso_oe_o;
    endproperty
    property p_drv;
        s_on |-> port_pin_shared_miso_oe_o;
    endproperty
    property p_mdir;
        (master_mode_i && !mode_fault_o)[*3] |-> port_pin_shared_sclk_oe_o
            && port_pin_shared_mosi_oe_o && !port_pin_shared_miso_oe_o;
    endproperty
    property p_sdir;
        (!master_mode_i)[*3] |-> !port_pin_shared_sclk_oe_o
            && !port_pin_shared_mosi_oe_o;
    endproperty
    property p_fset;
        (master_mode_i && !port_pin_shared_select_n_i)[*6] |-> mode_fault_o;
    endproperty
    property p_fdrop;
        mode_fault_o |-> !port_pin_shared_sclk_oe_o
            && !port_pin_shared_mosi_oe_o;
    endproperty
    // A fault may cut a bit short
    property p_half;
        disable iff (!rst_n_i || mode_fault_o || gpio_dir_i != 4'h0)
        $rose(port_pin_shared_sclk_o) |-> s_high ##1 !port_pin_shared_sclk_o;
    endproperty
    property p_setup;
        $rose(port_pin_shared_sclk_o) |-> $stable(port_pin_shared_mosi_o)
            && port_pin_shared_mosi_o == $past(port_pin_shared_mosi_o, 9);
    endproperty
    a_hiz: assert property (p_hiz) else $error("miso on idle");
    a_drv: assert property (p_drv) else $error("miso not driven");
    a_mdir: assert property (p_mdir) else $error("master dir");
    a_sdir: assert property (p_sdir) else $error("slave dir");
    a_fset: assert property (p_fset) else $error("no mode fault");
    a_fdrop: assert property (p_fdrop) else $error("fault drivers");
    a_half: assert property (p_half) else $error("sclk half");
    a_setup: assert property (p_setup) else $error("mosi setup");
endmodule
bind spipin_top spipin_top_asserts u_chk (.clk_i, .rst_n_i, .master_mode_i,
    .gpio_dir_i, .mode_fault_o, .port_pin_shared_select_n_i,
    .port_pin_shared_miso_oe_o, .port_pin_shared_mosi_o,
    .port_pin_shared_mosi_oe_o, .port_pin_shared_sclk_o,
    .port_pin_shared_sclk_oe_o);

//--- testbench/spipin_far_model.sv
// Behavioural far end: a slave when the port masters, else a master.
// Assumes the bench resolves each line from the enables.
`timescale 1ns/1ps
module spipin_far_model (
    // Resolved lines
    input wire logic sclk_i,
    input wire logic mosi_i,
    input wire logic miso_i,
    // Far-end drive values
    output logic sel_n_o,
    output logic sclk_o,
    output logic mosi_o,
    output logic miso_o,
    output logic [7:0] got_o
);
    logic [7:0] rep_q;
    initial begin
        sel_n_o = 1;
        sclk_o = 0;
        mosi_o = 0;
        miso_o = 0;
        got_o = 0;
        rep_q = 0;
    end
    // Far slave samples at the rise, after half a period of setup
    always @(posedge sclk_i) got_o <= {got_o[6:0], mosi_i};
    // Far slave shifts its reply at the fall
    always @(negedge sclk_i) begin
        rep_q <= rep_q << 1;
        miso_o <= rep_q[6];
    end
    task load(input logic [7:0] b);
        rep_q = b;
        miso_o = b[7];
    endtask
    // Clock pulses with select high, which must be ignored
    task noise;
        repeat (3) begin
            #32 sclk_o = 1;
            #32 sclk_o = 0;
        end
    endtask
    // Another master pulling select low
    task grab(input int ns);
        sel_n_o = 0;
        #(ns) sel_n_o = 1;
    endtask
    task xfer(input logic [7:0] b, output logic [7:0] r);
        sel_n_o = 0;
        #100;
        for (int i = 7; i >= 0; i--) begin
            mosi_o = b[i];
            // Taken before the rise, which moves the slave's bit on
            #32 r[i] = miso_i;
            sclk_o = 1;
            #32 sclk_o = 0;
        end
        #100 sel_n_o = 1;
        mosi_o = ~mosi_o; // Released line shows no stale bit
    endtask
endmodule

//--- testbench/spipin_top_tb.sv
// Self-checking bench for the shared-pin serial port.
// Assumes the far-end model and the bound checker.
`timescale 1ns/1ps
module spipin_top_tb;
    import spipin_pkg::*;
    logic clk_i, rst_n_i, master_mode_i, fault_clear_i, pin_sel_we_i;
    logic tx_valid_i, tx_ready_o, rx_valid_o, mode_fault_o, busy_o;
    spipin_pins_t pin_sel_i, gpio_dir_i, gpio_out_i, gpio_in_o;
    spipin_byte_t tx_data_i, rx_data_o, far_got, r;
    logic port_pin_shared_miso_o, port_pin_shared_miso_oe_o;
    logic port_pin_shared_mosi_o, port_pin_shared_mosi_oe_o;
    logic port_pin_shared_sclk_o, port_pin_shared_sclk_oe_o;
    logic port_pin_shared_select_n_o, port_pin_shared_select_n_oe_o;
    logic f_sel, f_sclk, f_mosi, f_miso;
    int n_errors = 0;
    int tests_run = 0;
    // Each line takes whoever enables it
    wire port_pin_shared_miso_i = port_pin_shared_miso_oe_o ?
        port_pin_shared_miso_o : f_miso;
    wire port_pin_shared_mosi_i = port_pin_shared_mosi_oe_o ?
        port_pin_shared_mosi_o : f_mosi;
    wire port_pin_shared_sclk_i = port_pin_shared_sclk_oe_o ?
        port_pin_shared_sclk_o : f_sclk;
    wire port_pin_shared_select_n_i = port_pin_shared_select_n_oe_o ?
        port_pin_shared_select_n_o : f_sel;
    spipin_top DUT (.clk_i, .rst_n_i, .master_mode_i, .fault_clear_i,
        .mode_fault_o, .busy_o, .pin_sel_we_i, .pin_sel_i, .gpio_dir_i,
        .gpio_out_i, .gpio_in_o, .tx_valid_i, .tx_data_i, .tx_ready_o,
        .rx_valid_o, .rx_data_o, .port_pin_shared_miso_i,
        .port_pin_shared_miso_o, .port_pin_shared_miso_oe_o,
        .port_pin_shared_mosi_i, .port_pin_shared_mosi_o,
        .port_pin_shared_mosi_oe_o, .port_pin_shared_sclk_i,
        .port_pin_shared_sclk_o, .port_pin_shared_sclk_oe_o,
        .port_pin_shared_select_n_i, .port_pin_shared_select_n_o,
        .port_pin_shared_select_n_oe_o);
    spipin_far_model far (.sclk_i(port_pin_shared_sclk_i),
        .mosi_i(port_pin_shared_mosi_i), .miso_i(port_pin_shared_miso_i),
        .sel_n_o(f_sel), .sclk_o(f_sclk), .mosi_o(f_mosi), .miso_o(f_miso),
        .got_o(far_got));
    // Core clock, 200 MHz
    initial begin
        clk_i = 0;
        forever #2.5 clk_i = ~clk_i;
    end
    task chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    task report_and_stop;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Held until a rising edge takes it with ready high
    task send(input spipin_byte_t b);
        @(negedge clk_i);
        tx_data_i = b;
        tx_valid_i = 1;
        for (int i = 0; i < 50 && tx_ready_o !== 1'b1; i++) @(negedge clk_i);
        @(negedge clk_i);
        tx_valid_i = 0;
    endtask
    task t_slave;
        send(8'h96);
        far.noise();
        far.xfer(8'h5a, r);
        chk(r, 8'h96, "slave reply");
        repeat (10) @(negedge clk_i);
        chk(rx_data_o, 8'h5a, "slave rx");
        $display("slave test done");
    endtask
    // Back to back bytes with only the end bits set, then only the end bits clear
    task t_master;
        logic [7:0] b;
        master_mode_i = 1;
        repeat (4) @(negedge clk_i);
        for (int i = 0; i < 2; i++) begin
            b = i ? 8'h7e : 8'h81;
            far.load(~b);
            send(b);
            chk(busy_o, 1'b1, "master busy");
            for (int k = 0; k < 400 && rx_valid_o !== 1'b1; k++)
                @(negedge clk_i);
            chk(rx_data_o, ~b, "master rx");
            chk(busy_o, 1'b0, "master idle");
            chk(far_got, b, "master tx");
        end
        $display("master test done");
    endtask
    // First pass faults while idle, second cuts a live byte short
    task t_fault;
        for (int p = 0; p < 2; p++) begin
            if (p) send(8'h3c);
            far.grab(60);
            chk(mode_fault_o, 1'b1, "fault set");
            chk(port_pin_shared_mosi_oe_o, 1'b0, "mosi dropped");
            chk(port_pin_shared_sclk_oe_o, 1'b0, "sclk dropped");
            chk(rx_data_o, 8'h81, "no byte from abort");
            fault_clear_i = 1;
            repeat (5) @(negedge clk_i);
            fault_clear_i = 0;
            @(negedge clk_i);
            chk(mode_fault_o, 1'b0, "fault cleared");
        end
        $display("fault test done");
    endtask
    // Direction set before ownership so the checker pauses first
    task t_gpio;
        gpio_dir_i = 4'h5;
        gpio_out_i = 4'h5;
        pin_sel_i = 4'hf;
        pin_sel_we_i = 1;
        @(negedge clk_i);
        pin_sel_we_i = 0;
        @(negedge clk_i);
        chk({port_pin_shared_select_n_oe_o, port_pin_shared_sclk_oe_o,
            port_pin_shared_mosi_oe_o, port_pin_shared_miso_oe_o},
            4'h5, "port enables");
        chk(port_pin_shared_miso_o, 1'b1, "port level");
        chk(port_pin_shared_select_n_o, 1'b0, "select level");
        @(negedge clk_i);
        chk(gpio_in_o & 4'hd, 4'hd, "port read back");
        pin_sel_i = 4'h0;
        pin_sel_we_i = 1;
        @(negedge clk_i);
        pin_sel_we_i = 0;
        gpio_dir_i = 4'h0;
        $display("port test done");
    endtask
    // Hang guard, far above the few microseconds expected
    initial begin
        #50000;
        n_errors++;
        report_and_stop();
    end
    initial begin
        rst_n_i = 0;
        {master_mode_i, fault_clear_i, pin_sel_we_i, tx_valid_i} = 4'h0;
        {pin_sel_i, gpio_dir_i, gpio_out_i} = 12'h000;
        tx_data_i = 8'h00;
        repeat (4) @(negedge clk_i);
        chk(gpio_in_o, 4'hf, "reset sync");
        chk({port_pin_shared_miso_oe_o, port_pin_shared_select_n_oe_o},
            2'h0, "reset enables");
        repeat (4) @(negedge clk_i);
        rst_n_i = 1;
        repeat (4) @(negedge clk_i);
        t_slave();
        t_master();
        t_fault();
        t_gpio();
        report_and_stop();
    end
endmodule
